// >>> core/mlfs_line.sv
// Function decode for one multi-purpose line: setting storage and role outputs.
// Assumes write requests are already decoded for this line.
`timescale 1ns/1ps
module mlfs_line (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        wrValid,
   input  wire logic [2:0]  wrValue,
   input  wire logic        halfDuplex,
   input  wire logic [1:0]  analogOutputMode,
   output logic [2:0]       funcSel,
   output logic             wrAccepted,
   output logic             wrRejected,
   output mlfs_pkg::mlfs_role_t role,
   output logic             mainOutOff,
   output logic             azimuthOn,
   output logic             sampleOn,
   output logic             selfTest,
   output logic             addrBit
);

   logic [2:0] func_q, func_d;
   logic       acc_q, acc_d;
   logic       rej_q, rej_d;

   always_comb begin
      func_d = func_q;
      acc_d  = 1'b0;
      rej_d  = 1'b0;
      if (wrValid) begin
         if (halfDuplex && wrValue <= mlfs_pkg::FUNC_MAX) begin
            func_d = wrValue;
            acc_d  = 1'b1;
         end else begin
            rej_d = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         func_q <= mlfs_pkg::FUNC_RESET;
         acc_q  <= 1'b0;
         rej_q  <= 1'b0;
      end else begin
         func_q <= func_d;
         acc_q  <= acc_d;
         rej_q  <= rej_d;
      end
   end

   assign funcSel    = func_q;
   assign wrAccepted = acc_q;
   assign wrRejected = rej_q;
   assign sampleOn   = func_q == mlfs_pkg::FUNC_AIN || func_q == mlfs_pkg::FUNC_SELFTEST;
   assign selfTest   = func_q == mlfs_pkg::FUNC_SELFTEST;
   assign mainOutOff = func_q == mlfs_pkg::FUNC_AIN;
   assign azimuthOn  = func_q == mlfs_pkg::FUNC_AZIMUTH
                       && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF;
   assign addrBit    = func_q == mlfs_pkg::FUNC_ADDRBIT;

   always_comb begin
      unique case (func_q)
         mlfs_pkg::FUNC_AIN, mlfs_pkg::FUNC_SELFTEST: role = mlfs_pkg::MLFS_ROLE_INPUT;
         mlfs_pkg::FUNC_AZIMUTH:                      role = mlfs_pkg::MLFS_ROLE_OUTPUT;
         mlfs_pkg::FUNC_ADDRBIT:                      role = mlfs_pkg::MLFS_ROLE_ADDR;
         default:                                     role = mlfs_pkg::MLFS_ROLE_IDLE;
      endcase
   end

   property p_full_duplex_hold;
      @(posedge sys_clk) disable iff (rst)
      (wrValid && !halfDuplex) |=> (func_q == $past(func_q) && wrRejected);
   endproperty
   a_full_duplex_hold: assert property (p_full_duplex_hold) else $error("write taken in full duplex");

   property p_range_reject;
      @(posedge sys_clk) disable iff (rst)
      (wrValid && wrValue > mlfs_pkg::FUNC_MAX) |=> (func_q == $past(func_q) && wrRejected);
   endproperty
   a_range_reject: assert property (p_range_reject) else $error("out-of-range value stored");

   property p_accept;
      @(posedge sys_clk) disable iff (rst)
      (wrValid && halfDuplex && wrValue <= mlfs_pkg::FUNC_MAX) |=> (func_q == $past(wrValue) && wrAccepted);
   endproperty
   a_accept: assert property (p_accept) else $error("legal write not stored");

   property p_in_range;
      @(posedge sys_clk) disable iff (rst) func_q <= mlfs_pkg::FUNC_MAX;
   endproperty
   a_in_range: assert property (p_in_range) else $error("setting out of range");

   property p_azimuth;
      @(posedge sys_clk) disable iff (rst)
      (analogOutputMode == mlfs_pkg::AOUT_MODE_OFF) |-> !azimuthOn;
   endproperty
   a_azimuth: assert property (p_azimuth) else $error("azimuth driven in mode 2");

endmodule

// >>> core/mlfs_pkg.sv
// Package for the multi-line function select block: setting codes, field widths, structs.
// Assumes a single 250 MHz clock domain; all users reference it with mlfs_pkg::name.
package mlfs_pkg;

   // ==========================================================================
   // Setting codes and widths
   localparam int          FUNC_W        = 3;
   localparam int          SAMPLE_W      = 16;
   localparam int          MODE_W        = 2;
   localparam logic [2:0]  FUNC_UNUSED   = 3'h0;
   localparam logic [2:0]  FUNC_AIN      = 3'h1;
   localparam logic [2:0]  FUNC_SELFTEST = 3'h2;
   localparam logic [2:0]  FUNC_AZIMUTH  = 3'h3;
   localparam logic [2:0]  FUNC_ADDRBIT  = 3'h4;
   localparam logic [2:0]  FUNC_MAX      = 3'h4;
   localparam logic [2:0]  FUNC_RESET    = 3'h0;
   localparam logic [1:0]  AOUT_MODE_OFF = 2'h2;
   localparam logic [1:0]  AOUT_MODE_VOLT = 2'h0;
   localparam logic [15:0] SAMPLE_FULL   = 16'hFFFF;

   // ==========================================================================
   // Timing: one conversion per sample period
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int CLK_PERIOD_NS    = 4;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

   // ==========================================================================
   // Carriers
   typedef enum logic [1:0] {
      MLFS_ROLE_IDLE,
      MLFS_ROLE_INPUT,
      MLFS_ROLE_OUTPUT,
      MLFS_ROLE_ADDR
   } mlfs_role_t;

   typedef struct packed {
      logic             valid;
      logic             lineSel;   // 0 first line, 1 fourth line
      logic [2:0]       value;
   } mlfs_wr_t;

   typedef struct packed {
      logic             valid;
      logic [15:0]      code;
   } mlfs_sample_t;

endpackage

// >>> core/mlfs_sampler.sv
// Cyclic analog sampler for one multi-purpose line.
// Assumes the converter code is synchronous to sys_clk and scaled to full range.
`timescale 1ns/1ps
module mlfs_sampler #(
   parameter int ADC_W = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             enable,
   input  wire logic             tick,
   input  wire logic [ADC_W-1:0] adcCode,
   output mlfs_pkg::mlfs_sample_t sample
);

   mlfs_pkg::mlfs_sample_t sample_q, sample_d;

   always_comb begin
      sample_d       = sample_q;
      sample_d.valid = 1'b0;
      if (!enable) begin
         sample_d.code = '0;
      end else if (tick) begin
         sample_d.valid = 1'b1;
         sample_d.code  = adcCode;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sample_q <= '0;
      end else begin
         sample_q <= sample_d;
      end
   end

   assign sample = sample_q;

   property p_sample_on_tick;
      @(posedge sys_clk) disable iff (rst)
      (enable && tick) |=> (sample.valid && sample.code == $past(adcCode));
   endproperty
   a_sample_on_tick: assert property (p_sample_on_tick) else $error("sample not taken on tick");

endmodule

// >>> core/mlfs_top.sv
// Top of the multi-line function select block: two line decoders and two samplers.
// Assumes a configuration parser delivers decoded writes and the analog converters give 16-bit codes.
`timescale 1ns/1ps
module mlfs_top #(
   parameter int SAMPLE_CYCLES = mlfs_pkg::SAMPLE_CYCLES
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire mlfs_pkg::mlfs_wr_t cfgWrite,
   input  wire logic             halfDuplex,
   input  wire logic [1:0]       analogOutputMode,
   input  wire logic [15:0]      firstLineAdc,
   input  wire logic [15:0]      fourthLineAdc,
   input  wire logic             firstLineLevel,
   input  wire logic             fourthLineLevel,
   output logic [2:0]            firstLineFunctionSelect,
   output logic [2:0]            fourthLineFunctionSelect,
   output logic                  cfgAccepted,
   output logic                  cfgRejected,
   output logic                  fullDuplexAllowed,
   output logic                  windSpeedOutEnable,
   output logic                  windAngleOutEnable,
   output logic                  azimuthSpeedOutEnable,
   output logic                  azimuthAngleOutEnable,
   output logic                  firstSelfTest,
   output logic                  fourthSelfTest,
   output mlfs_pkg::mlfs_sample_t firstLineSample,
   output mlfs_pkg::mlfs_sample_t fourthLineSample,
   output logic [1:0]            instrumentAddressBits,
   output logic [1:0]            instrumentAddressValid
);

   // ==========================================================================
   // Sample tick divider
   logic [$clog2(SAMPLE_CYCLES)-1:0] div_q, div_d;
   logic                             tick;

   always_comb begin
      tick  = div_q == ($clog2(SAMPLE_CYCLES))'(SAMPLE_CYCLES - 1);
      div_d = tick ? '0 : div_q + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // ==========================================================================
   // Line decoders
   logic                 acc1, acc4, rej1, rej4;
   logic                 off1, off4, az1, az4, smp1, smp4, st1, st4, ab1, ab4;
   mlfs_pkg::mlfs_role_t role1, role4;

   mlfs_line u_first (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .wrValid          (cfgWrite.valid && !cfgWrite.lineSel),
      .wrValue          (cfgWrite.value),
      .halfDuplex       (halfDuplex),
      .analogOutputMode (analogOutputMode),
      .funcSel          (firstLineFunctionSelect),
      .wrAccepted       (acc1),
      .wrRejected       (rej1),
      .role             (role1),
      .mainOutOff       (off1),
      .azimuthOn        (az1),
      .sampleOn         (smp1),
      .selfTest         (st1),
      .addrBit          (ab1)
   );

   mlfs_line u_fourth (
      .sys_clk          (sys_clk),
      .rst              (rst),
      .wrValid          (cfgWrite.valid && cfgWrite.lineSel),
      .wrValue          (cfgWrite.value),
      .halfDuplex       (halfDuplex),
      .analogOutputMode (analogOutputMode),
      .funcSel          (fourthLineFunctionSelect),
      .wrAccepted       (acc4),
      .wrRejected       (rej4),
      .role             (role4),
      .mainOutOff       (off4),
      .azimuthOn        (az4),
      .sampleOn         (smp4),
      .selfTest         (st4),
      .addrBit          (ab4)
   );

   // ==========================================================================
   // Samplers; self test reuses the same input path.
   mlfs_sampler #(.ADC_W(mlfs_pkg::SAMPLE_W)) u_samp1 (
      .sys_clk (sys_clk),
      .rst     (rst),
      .enable  (smp1),
      .tick    (tick),
      .adcCode (firstLineAdc),
      .sample  (firstLineSample)
   );

   mlfs_sampler #(.ADC_W(mlfs_pkg::SAMPLE_W)) u_samp4 (
      .sys_clk (sys_clk),
      .rst     (rst),
      .enable  (smp4),
      .tick    (tick),
      .adcCode (fourthLineAdc),
      .sample  (fourthLineSample)
   );

   // ==========================================================================
   // Outputs
   logic [1:0] addr_q, addr_d;

   always_comb begin
      addr_d = {ab4 ? fourthLineLevel : 1'b0, ab1 ? firstLineLevel : 1'b0};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         addr_q <= '0;
      end else begin
         addr_q <= addr_d;
      end
   end

   assign instrumentAddressBits  = addr_q;
   assign instrumentAddressValid = {ab4, ab1};
   assign cfgAccepted            = acc1 | acc4;
   assign cfgRejected            = rej1 | rej4;
   // Full duplex only once both lines are back to unused.
   assign fullDuplexAllowed      = role1 == mlfs_pkg::MLFS_ROLE_IDLE
                                   && role4 == mlfs_pkg::MLFS_ROLE_IDLE;
   // Read-back needs the speed output live, so only plain input mode or AOUT_MODE_OFF kills it.
   assign windSpeedOutEnable     = !off1 && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF;
   assign windAngleOutEnable     = !off4 && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF;
   assign azimuthSpeedOutEnable  = az1;
   assign azimuthAngleOutEnable  = az4;
   assign firstSelfTest          = st1;
   assign fourthSelfTest         = st4;

   sequence s_in_mode1;
      firstLineFunctionSelect == mlfs_pkg::FUNC_AIN;
   endsequence

   property p_speed_off;
      @(posedge sys_clk) disable iff (rst) s_in_mode1 |-> !windSpeedOutEnable;
   endproperty
   a_speed_off: assert property (p_speed_off) else $error("speed output on in input mode");

   property p_angle_off;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect == mlfs_pkg::FUNC_AIN) |-> !windAngleOutEnable;
   endproperty
   a_angle_off: assert property (p_angle_off) else $error("angle output on in input mode");

   property p_selftest_samples;
      @(posedge sys_clk) disable iff (rst)
      (fourthSelfTest && tick) |=> fourthLineSample.valid;
   endproperty
   a_selftest_samples: assert property (p_selftest_samples) else $error("self test not sampled");

   property p_cyclic;
      @(posedge sys_clk) disable iff (rst)
      (firstSelfTest && tick) |=> (firstLineSample.valid ##1 !firstLineSample.valid);
   endproperty
   a_cyclic: assert property (p_cyclic) else $error("sample pulse not one cycle");

   property p_addr;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect == mlfs_pkg::FUNC_ADDRBIT) |=> instrumentAddressBits[1] == $past(fourthLineLevel);
   endproperty
   a_addr: assert property (p_addr) else $error("address bit 1 not captured");

   property p_fdx;
      @(posedge sys_clk) disable iff (rst)
      fullDuplexAllowed |-> (firstLineFunctionSelect == 3'h0 && fourthLineFunctionSelect == 3'h0);
   endproperty
   a_fdx: assert property (p_fdx) else $error("full duplex allowed with line in use");

   property p_az4;
      @(posedge sys_clk) disable iff (rst)
      azimuthAngleOutEnable |-> analogOutputMode != mlfs_pkg::AOUT_MODE_OFF;
   endproperty
   a_az4: assert property (p_az4) else $error("azimuth angle in mode 2");

   // ==========================================================================
   // Output gating checks
   // The enables below feed analog drivers directly, so a glitch-free level is
   // assumed downstream; these checks pin the level to the stored setting.
   property p_az1_gate;
      @(posedge sys_clk) disable iff (rst)
      azimuthSpeedOutEnable |-> analogOutputMode != mlfs_pkg::AOUT_MODE_OFF;
   endproperty
   a_az1_gate: assert property (p_az1_gate) else $error("azimuth speed in mode 2");

   property p_az1_on;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect == mlfs_pkg::FUNC_AZIMUTH && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF)
      |-> azimuthSpeedOutEnable;
   endproperty
   a_az1_on: assert property (p_az1_on) else $error("azimuth speed not driven");

   property p_az4_on;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect == mlfs_pkg::FUNC_AZIMUTH && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF)
      |-> azimuthAngleOutEnable;
   endproperty
   a_az4_on: assert property (p_az4_on) else $error("azimuth angle not driven");

   // Self test reads the output back, so only plain input mode or AOUT_MODE_OFF may silence it.
   property p_speed_on;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect != mlfs_pkg::FUNC_AIN && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF)
      |-> windSpeedOutEnable;
   endproperty
   a_speed_on: assert property (p_speed_on) else $error("speed output silenced");

   property p_angle_on;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect != mlfs_pkg::FUNC_AIN && analogOutputMode != mlfs_pkg::AOUT_MODE_OFF)
      |-> windAngleOutEnable;
   endproperty
   a_angle_on: assert property (p_angle_on) else $error("angle output silenced");

   property p_fdx_idle;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect == mlfs_pkg::FUNC_UNUSED && fourthLineFunctionSelect == mlfs_pkg::FUNC_UNUSED)
      |-> fullDuplexAllowed;
   endproperty
   a_fdx_idle: assert property (p_fdx_idle) else $error("full duplex refused with lines unused");

   // ==========================================================================
   // Sampling checks
   property p_first_input;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect == mlfs_pkg::FUNC_AIN && tick)
      |=> (firstLineSample.valid && firstLineSample.code == $past(firstLineAdc));
   endproperty
   a_first_input: assert property (p_first_input) else $error("first line input not sampled");

   property p_fourth_input;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect == mlfs_pkg::FUNC_AIN && tick)
      |=> (fourthLineSample.valid && fourthLineSample.code == $past(fourthLineAdc));
   endproperty
   a_fourth_input: assert property (p_fourth_input) else $error("fourth line input not sampled");

   property p_first_idle;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect != mlfs_pkg::FUNC_AIN && firstLineFunctionSelect != mlfs_pkg::FUNC_SELFTEST)
      |=> (!firstLineSample.valid && firstLineSample.code == 16'h0000);
   endproperty
   a_first_idle: assert property (p_first_idle) else $error("first line sampled while unused");

   property p_fourth_idle;
      @(posedge sys_clk) disable iff (rst)
      (fourthLineFunctionSelect != mlfs_pkg::FUNC_AIN && fourthLineFunctionSelect != mlfs_pkg::FUNC_SELFTEST)
      |=> (!fourthLineSample.valid && fourthLineSample.code == 16'h0000);
   endproperty
   a_fourth_idle: assert property (p_fourth_idle) else $error("fourth line sampled while unused");

   // ==========================================================================
   // Address and write answer checks
   property p_addr0;
      @(posedge sys_clk) disable iff (rst)
      (firstLineFunctionSelect == mlfs_pkg::FUNC_ADDRBIT) |=> instrumentAddressBits[0] == $past(firstLineLevel);
   endproperty
   a_addr0: assert property (p_addr0) else $error("address bit 0 not captured");

   property p_addr0_idle;
      @(posedge sys_clk) disable iff (rst)
      !instrumentAddressValid[0] |=> !instrumentAddressBits[0];
   endproperty
   a_addr0_idle: assert property (p_addr0_idle) else $error("address bit 0 set while unused");

   property p_addr1_idle;
      @(posedge sys_clk) disable iff (rst)
      !instrumentAddressValid[1] |=> !instrumentAddressBits[1];
   endproperty
   a_addr1_idle: assert property (p_addr1_idle) else $error("address bit 1 set while unused");

   // Every write gets exactly one answer, so a host can pace itself on it.
   sequence s_write_req;
      cfgWrite.valid;
   endsequence

   sequence s_write_answer;
      cfgAccepted || cfgRejected;
   endsequence

   property p_write_answer;
      @(posedge sys_clk) disable iff (rst)
      s_write_req |=> s_write_answer;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("write left unanswered");

   property p_one_answer;
      @(posedge sys_clk) disable iff (rst)
      !(cfgAccepted && cfgRejected);
   endproperty
   a_one_answer: assert property (p_one_answer) else $error("write both accepted and rejected");

endmodule

// >>> verification/mlfs_host_model.sv
// Far-side model: configuration host and the analog equipment on both lines.
// Assumes the bench calls its tasks and that writes arrive already decoded.
`timescale 1ns/1ps
module mlfs_host_model (
   input  wire logic            sys_clk,
   output mlfs_pkg::mlfs_wr_t   cfgWrite,
   output logic [15:0]          firstLineAdc,
   output logic [15:0]          fourthLineAdc,
   output logic                 firstLineLevel,
   output logic                 fourthLineLevel
);
   // ==========================================================================
   // Idle values
   initial begin
      cfgWrite = '0;
      firstLineAdc = 16'h0000;
      fourthLineAdc = 16'h0000;
      firstLineLevel = 1'b0;
      fourthLineLevel = 1'b0;
   end

   // ==========================================================================
   // One decoded command: address and code already matched, value is the parameter.
   task automatic write(input logic sel, input logic [2:0] val);
      @(posedge sys_clk);
      cfgWrite <= '{valid: 1'b1, lineSel: sel, value: val};
      @(posedge sys_clk);
      cfgWrite <= '0;
      #1;
   endtask

   task automatic setAnalog(input logic [15:0] a, input logic [15:0] b, input logic la, input logic lb);
      @(posedge sys_clk);
      firstLineAdc <= a;
      fourthLineAdc <= b;
      firstLineLevel <= la;
      fourthLineLevel <= lb;
   endtask
endmodule

// >>> verification/multi_line_function_select_tb.sv
// Self-checking bench for the multi-line function select block.
// Assumes a short sample period through the SAMPLE_CYCLES parameter.
`timescale 1ns/1ps
module multi_line_function_select_tb;
   localparam int SampleCyc = 4;
   logic                   sys_clk = 1'b0;
   logic                   rst = 1'b1;
   logic                   halfDuplex = 1'b1;
   logic [1:0]             analogOutputMode = 2'h0;
   mlfs_pkg::mlfs_wr_t     cfgWrite;
   logic [15:0]            firstLineAdc;
   logic [15:0]            fourthLineAdc;
   logic                   firstLineLevel;
   logic                   fourthLineLevel;
   logic [2:0]             sel [2];
   logic                   cfgAccepted;
   logic                   cfgRejected;
   logic                   fullDuplexAllowed;
   logic [1:0]             mainEn;
   logic [1:0]             azimEn;
   logic [1:0]             selfT;
   mlfs_pkg::mlfs_sample_t smp [2];
   logic [1:0]             instrumentAddressBits;
   logic [1:0]             instrumentAddressValid;
   int                     error_cnt = 0;
   int                     checks = 0;

   always #2 sys_clk = ~sys_clk;

   mlfs_host_model host_u (.sys_clk(sys_clk), .cfgWrite(cfgWrite), .firstLineAdc(firstLineAdc),
      .fourthLineAdc(fourthLineAdc), .firstLineLevel(firstLineLevel), .fourthLineLevel(fourthLineLevel));

   mlfs_top #(.SAMPLE_CYCLES(SampleCyc)) dut_u (.sys_clk(sys_clk), .rst(rst), .cfgWrite(cfgWrite),
      .halfDuplex(halfDuplex), .analogOutputMode(analogOutputMode), .firstLineAdc(firstLineAdc),
      .fourthLineAdc(fourthLineAdc), .firstLineLevel(firstLineLevel), .fourthLineLevel(fourthLineLevel),
      .firstLineFunctionSelect(sel[0]), .fourthLineFunctionSelect(sel[1]), .cfgAccepted(cfgAccepted),
      .cfgRejected(cfgRejected), .fullDuplexAllowed(fullDuplexAllowed), .windSpeedOutEnable(mainEn[0]),
      .windAngleOutEnable(mainEn[1]), .azimuthSpeedOutEnable(azimEn[0]), .azimuthAngleOutEnable(azimEn[1]),
      .firstSelfTest(selfT[0]), .fourthSelfTest(selfT[1]), .firstLineSample(smp[0]),
      .fourthLineSample(smp[1]), .instrumentAddressBits(instrumentAddressBits),
      .instrumentAddressValid(instrumentAddressValid));

   // ==========================================================================
   // Compare and closing tasks
   task automatic chkBit(input string name, input logic exp, input logic seen);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", name, exp, seen);
      end
   endtask

   task automatic chkVal(input string name, input logic [15:0] exp, input logic [15:0] seen);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // ==========================================================================
   // Scenarios
   task automatic test_reset();
      for (int l = 0; l < 2; l++) begin
         chkVal("setting", 16'h0000, {13'h0000, sel[l]});
         chkBit("mainEn", 1'b1, mainEn[l]);
         chkVal("code", 16'h0000, smp[l].code);
      end
      chkBit("fullDuplexAllowed", 1'b1, fullDuplexAllowed);
      $display("test_reset done");
   endtask

   // A refused write must leave the stored setting alone.
   task automatic test_refused();
      @(posedge sys_clk);
      halfDuplex <= 1'b0;
      for (int l = 0; l < 2; l++) begin
         host_u.write(l[0], 3'h1);
         chkBit("rejected", 1'b1, cfgRejected);
         chkVal("setting", 16'h0000, {13'h0000, sel[l]});
      end
      @(posedge sys_clk);
      halfDuplex <= 1'b1;
      for (int v = 5; v < 8; v++) begin
         host_u.write(v[0], v[2:0]);
         chkBit("rejected", 1'b1, cfgRejected);
         chkBit("accepted", 1'b0, cfgAccepted);
         chkVal("setting", 16'h0000, {13'h0000, sel[v % 2]});
      end
      $display("test_refused done");
   endtask

   task automatic test_functions();
      for (int l = 0; l < 2; l++) begin
         for (int v = 0; v < 5; v++) begin
            host_u.write(l[0], v[2:0]);
            chkBit("accepted", 1'b1, cfgAccepted);
            chkVal("setting", v[15:0], {13'h0000, sel[l]});
            chkBit("mainEn", v != 1, mainEn[l]);
            chkBit("azimEn", v == 3, azimEn[l]);
            chkBit("selfTest", v == 2, selfT[l]);
            chkBit("addrValid", v == 4, instrumentAddressValid[l]);
            chkBit("fullDuplexAllowed", v == 0, fullDuplexAllowed);
         end
         host_u.write(l[0], 3'h3);
         @(posedge sys_clk);
         analogOutputMode <= 2'h1;
         @(posedge sys_clk);
         #1;
         chkBit("azimEnCurrent", 1'b1, azimEn[l]);
         @(posedge sys_clk);
         analogOutputMode <= 2'h2;
         @(posedge sys_clk);
         #1;
         chkBit("azimEnOff", 1'b0, azimEn[l]);
         @(posedge sys_clk);
         analogOutputMode <= 2'h0;
         host_u.write(l[0], 3'h0);
      end
      $display("test_functions done");
   endtask

   task automatic test_sampling();
      int n [2];
      host_u.setAnalog(16'hFFFF, 16'h5A3C, 1'b0, 1'b0);
      // Each line takes one turn as plain input and one as self test.
      for (int p = 0; p < 2; p++) begin
         n = '{0, 0};
         host_u.write(1'b0, p == 0 ? 3'h1 : 3'h2);
         host_u.write(1'b1, p == 0 ? 3'h2 : 3'h1);
         repeat (4 * SampleCyc) begin
            @(posedge sys_clk);
            #1;
            for (int l = 0; l < 2; l++) begin
               if (smp[l].valid === 1'b1) begin
                  n[l]++;
                  chkVal("code", l == 0 ? 16'hFFFF : 16'h5A3C, smp[l].code);
               end
            end
         end
         chkVal("firstCount", 16'h0004, n[0][15:0]);
         chkVal("fourthCount", 16'h0004, n[1][15:0]);
      end
      host_u.write(1'b0, 3'h0);
      host_u.write(1'b1, 3'h0);
      repeat (2 * SampleCyc) begin
         @(posedge sys_clk);
         #1;
         chkBit("validOff", 1'b0, smp[0].valid | smp[1].valid);
      end
      chkVal("codeOff", 16'h0000, smp[0].code | smp[1].code);
      $display("test_sampling done");
   endtask

   task automatic test_address();
      host_u.write(1'b0, 3'h4);
      host_u.write(1'b1, 3'h4);
      for (int k = 1; k < 3; k++) begin
         host_u.setAnalog(16'h0000, 16'h0000, k[0], k[1]);
         repeat (2) @(posedge sys_clk);
         #1;
         chkVal("addrBits", k[15:0], {14'h0000, instrumentAddressBits});
      end
      host_u.write(1'b1, 3'h0);
      repeat (2) @(posedge sys_clk);
      #1;
      chkBit("addrBit1Off", 1'b0, instrumentAddressBits[1]);
      $display("test_address done");
   endtask

   // ==========================================================================
   // Main sequence and watchdog
   initial begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      test_reset();
      test_refused();
      test_functions();
      test_sampling();
      test_address();
      finish_test();
   end

   // The whole run needs well under a thousand cycles, so this margin only catches a hang.
   initial begin
      #40000;
      error_cnt++;
      $display("[FAIL] watchdog expected done seen hang");
      finish_test();
   end
endmodule
